// [design/acss_clock_select.sv]
// register file and source decode for the audio clock tree selectors
// assumes register accesses come decoded from the control port, one byte per access
// assumes candidate clocks and the auto-set request are synchronous to core_clk

module acss_clock_select (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       reset,
    // register access from the control port
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [7:0]                      reg_rdata,
    // auto set mode
    input  wire logic                       clock_auto_set,
    input  wire logic [2:0]                 auto_ref_code,
    // candidate clocks
    input  wire acss_pkg::acss_clk_in_type  clk_in,
    // selected clocks and the effective reference source
    output acss_pkg::acss_clk_out_type      clk_out,
    output logic [3:0]                      pll_ref_src
);
    import acss_pkg::*;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    logic [7:0] ref_dsp_q, ref_dsp_d;
    logic [7:0] dac_osr_q, dac_osr_d;
    logic [7:0] pump_q, pump_d;
    logic [7:0] pick_a_q, pick_a_d;
    logic [7:0] pick_b_q, pick_b_d;
    logic [7:0] pick_ref_q, pick_ref_d;
    logic [7:0] rdata_q, rdata_d;

    // reserved bits are not stored and read as zero
    always_comb begin
        ref_dsp_d  = ref_dsp_q;
        dac_osr_d  = dac_osr_q;
        pump_d     = pump_q;
        pick_a_d   = pick_a_q;
        pick_b_d   = pick_b_q;
        pick_ref_d = pick_ref_q;
        if (reg_wr) begin
            unique case (reg_addr)
                ACSS_REG_REF_DSP:  ref_dsp_d  = reg_wdata & ACSS_MASK_TWO;
                ACSS_REG_DAC_OSR:  dac_osr_d  = reg_wdata & ACSS_MASK_TWO;
                ACSS_REG_PUMP:     pump_d     = reg_wdata & ACSS_MASK_LOW;
                ACSS_REG_PICK_A:   pick_a_d   = reg_wdata & ACSS_MASK_TWO;
                ACSS_REG_PICK_B:   pick_b_d   = reg_wdata & ACSS_MASK_TWO;
                ACSS_REG_PICK_REF: pick_ref_d = reg_wdata & ACSS_MASK_LOW;
                default: begin
                end
            endcase
        end
    end

    // unmapped offsets read as zero
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                ACSS_REG_REF_DSP:  rdata_d = ref_dsp_q;
                ACSS_REG_DAC_OSR:  rdata_d = dac_osr_q;
                ACSS_REG_PUMP:     rdata_d = pump_q;
                ACSS_REG_PICK_A:   rdata_d = pick_a_q;
                ACSS_REG_PICK_B:   rdata_d = pick_b_q;
                ACSS_REG_PICK_REF: rdata_d = pick_ref_q;
                default:           rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ref_dsp_q  <= ACSS_REG_RESET;
            dac_osr_q  <= ACSS_REG_RESET;
            pump_q     <= ACSS_REG_RESET;
            pick_a_q   <= ACSS_REG_RESET;
            pick_b_q   <= ACSS_REG_RESET;
            pick_ref_q <= ACSS_REG_RESET;
            rdata_q    <= 8'h00;
        end else begin
            ref_dsp_q  <= ref_dsp_d;
            dac_osr_q  <= dac_osr_d;
            pump_q     <= pump_d;
            pick_a_q   <= pick_a_d;
            pick_b_q   <= pick_b_d;
            pick_ref_q <= pick_ref_d;
            rdata_q    <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // field views
    logic [2:0] pll_ref_select;
    logic [2:0] dsp_clk_select;
    logic [2:0] dac_clk_select;
    logic [2:0] oversampling_clk_select;
    logic [2:0] pump_clk_select;
    logic [2:0] dsp_gpio_pick;
    logic [2:0] dac_gpio_pick;
    logic [2:0] oversampling_gpio_pick;
    logic [2:0] pump_gpio_pick;
    logic [2:0] pll_ref_gpio_pick;

    assign pll_ref_select          = {ref_dsp_q[ACSS_REF_HI_LSB +: 2],
                                      ref_dsp_q[ACSS_REF_LO_BIT]};
    assign dsp_clk_select          = ref_dsp_q[ACSS_LOW_LSB +: ACSS_FIELD_W];
    assign dac_clk_select          = dac_osr_q[ACSS_HIGH_LSB +: ACSS_FIELD_W];
    assign oversampling_clk_select = dac_osr_q[ACSS_LOW_LSB +: ACSS_FIELD_W];
    assign pump_clk_select         = pump_q[ACSS_LOW_LSB +: ACSS_FIELD_W];
    assign dsp_gpio_pick           = pick_a_q[ACSS_HIGH_LSB +: ACSS_FIELD_W];
    assign dac_gpio_pick           = pick_a_q[ACSS_LOW_LSB +: ACSS_FIELD_W];
    assign oversampling_gpio_pick  = pick_b_q[ACSS_LOW_LSB +: ACSS_FIELD_W];
    assign pump_gpio_pick          = pick_b_q[ACSS_HIGH_LSB +: ACSS_FIELD_W];
    assign pll_ref_gpio_pick       = pick_ref_q[ACSS_LOW_LSB +: ACSS_FIELD_W];

    function automatic logic [3:0] pick_src(input logic [2:0] pick);
        logic [3:0] idx;
        idx = ACSS_SRC_MUTE;
        if (pick == ACSS_PICK_GPIO0) begin
            idx = ACSS_SRC_GPIO0;
        end else if (pick == ACSS_PICK_GPIO2) begin
            idx = ACSS_SRC_GPIO2;
        end
        return idx;
    endfunction : pick_src

    function automatic logic [3:0] ref_src(input logic [2:0] code, input logic [2:0] pick);
        logic [3:0] idx;
        idx = ACSS_SRC_MUTE;
        unique case (code)
            ACSS_CODE_0: idx = ACSS_SRC_MCLK;
            ACSS_CODE_1: idx = ACSS_SRC_SCLK;
            ACSS_CODE_2: idx = ACSS_SRC_OSC;
            ACSS_CODE_3: idx = pick_src(pick);
            default:     idx = ACSS_SRC_MUTE;
        endcase
        return idx;
    endfunction : ref_src

    function automatic logic [3:0] div_src(input logic [2:0] code, input logic [2:0] pick);
        logic [3:0] idx;
        idx = ACSS_SRC_MUTE;
        unique case (code)
            ACSS_CODE_0: idx = ACSS_SRC_MASTER;
            ACSS_CODE_1: idx = ACSS_SRC_PLL;
            ACSS_CODE_2: idx = ACSS_SRC_OSC;
            ACSS_CODE_3: idx = ACSS_SRC_MCLK;
            ACSS_CODE_4: idx = ACSS_SRC_SCLK;
            ACSS_CODE_5: idx = pick_src(pick);
            default:     idx = ACSS_SRC_MUTE;
        endcase
        return idx;
    endfunction : div_src

    function automatic logic [3:0] osr_src(input logic [2:0] code, input logic [2:0] pick);
        logic [3:0] idx;
        idx = ACSS_SRC_MUTE;
        unique case (code)
            ACSS_CODE_0: idx = ACSS_SRC_DAC;
            ACSS_CODE_1: idx = ACSS_SRC_MASTER;
            ACSS_CODE_2: idx = ACSS_SRC_PLL;
            ACSS_CODE_3: idx = ACSS_SRC_OSC;
            ACSS_CODE_4: idx = ACSS_SRC_MCLK;
            ACSS_CODE_5: idx = ACSS_SRC_SCLK;
            ACSS_CODE_6: idx = pick_src(pick);
            default:     idx = ACSS_SRC_MUTE;
        endcase
        return idx;
    endfunction : osr_src

    logic [3:0] ref_idx;
    logic [3:0] dsp_idx;
    logic [3:0] dac_idx;
    logic [3:0] osr_idx;
    logic [3:0] pump_idx;

    // auto set mode picks its own reference code; the written one is kept but unused
    assign ref_idx  = clock_auto_set ? ref_src(auto_ref_code, pll_ref_gpio_pick)
                                     : ref_src(pll_ref_select, pll_ref_gpio_pick);
    assign dsp_idx  = div_src(dsp_clk_select, dsp_gpio_pick);
    assign dac_idx  = div_src(dac_clk_select, dac_gpio_pick);
    assign osr_idx  = osr_src(oversampling_clk_select, oversampling_gpio_pick);
    assign pump_idx = osr_src(pump_clk_select, pump_gpio_pick);
    assign pll_ref_src = ref_idx;

    // the dac output feeds the oversampling and pump selectors after its own
    // switch register, so those see one cycle of extra latency on the dac clock
    logic [ACSS_SRC_N-1:0] src_vec;
    logic                  dac_clk;

    assign src_vec = {dac_clk, clk_in.gpio2, clk_in.gpio0, clk_in.sclk, clk_in.mclk,
                      clk_in.osc, clk_in.pll, clk_in.master, 1'b0};

    logic [4:0] [3:0] want_idx;
    logic [4:0]       sel_clk;
    logic [4:0] [3:0] cur_idx;

    assign want_idx = {ref_idx, dsp_idx, dac_idx, osr_idx, pump_idx};

    for (genvar g = 0; g < 5; g++) begin : g_mux
        acss_glitch_free_mux #(
            .N (ACSS_SRC_N),
            .W (ACSS_SRC_W)
        ) u_mux (
            .core_clk (core_clk),
            .reset    (reset),
            .src_vec  (src_vec),
            .want_sel (want_idx[g]),
            .clk_out  (sel_clk[g]),
            .cur_sel  (cur_idx[g])
        );
    end

    assign dac_clk              = sel_clk[2];
    assign clk_out.pll_ref      = sel_clk[4];
    assign clk_out.dsp          = sel_clk[3];
    assign clk_out.dac          = sel_clk[2];
    assign clk_out.oversampling = sel_clk[1];
    assign clk_out.pump         = sel_clk[0];

    sequence write_dac_osr_s;
        reg_wr && reg_addr == ACSS_REG_DAC_OSR ##1 reg_rd && reg_addr == ACSS_REG_DAC_OSR;
    endsequence

    reg_readback_a: assert property (
        write_dac_osr_s |=> reg_rdata == ($past(reg_wdata, 2) & ACSS_MASK_TWO))
        else $error("written select register did not read back");

    auto_override_a: assert property (
        clock_auto_set && auto_ref_code == ACSS_CODE_1 |-> ref_idx == ACSS_SRC_SCLK)
        else $error("auto set mode did not override reference select");

    dsp_master_a: assert property (
        dsp_clk_select == ACSS_CODE_0 |-> dsp_idx == ACSS_SRC_MASTER)
        else $error("dsp code 000 is not the master clock");

    dac_sclk_a: assert property (
        dac_clk_select == ACSS_CODE_4 |-> dac_idx == ACSS_SRC_SCLK)
        else $error("dac code 100 is not sclk");

    ref_decode_a: assert property (
        !clock_auto_set && pll_ref_select == ACSS_CODE_2 |-> ref_idx == ACSS_SRC_OSC)
        else $error("reference code 010 is not the oscillator");

    ref_mute_a: assert property (
        !clock_auto_set && pll_ref_select > ACSS_CODE_3 |-> ref_idx == ACSS_SRC_MUTE)
        else $error("reserved reference code not muted");

    dsp_gpio_a: assert property (
        dsp_clk_select == ACSS_CODE_5 && dsp_gpio_pick == ACSS_PICK_GPIO0
        |-> dsp_idx == ACSS_SRC_GPIO0)
        else $error("dsp gpio pick 011 is not gpio0");

    dac_pick_a: assert property (
        dac_clk_select == ACSS_CODE_5 && dac_gpio_pick == ACSS_CODE_4
        |-> dac_idx == ACSS_SRC_MUTE)
        else $error("dac gpio pick 100 gives a clock");

    osr_dac_a: assert property (
        oversampling_clk_select == ACSS_CODE_0 |-> osr_idx == ACSS_SRC_DAC)
        else $error("oversampling code 000 is not the dac clock");

    pump_gpio_a: assert property (
        pump_clk_select == ACSS_CODE_6 && pump_gpio_pick == ACSS_PICK_GPIO2
        |-> pump_idx == ACSS_SRC_GPIO2)
        else $error("pump gpio selection wrong");

    // the old source may still be finishing its high phase, so the mute is
    // judged only once the selector has actually landed on the mute index
    dsp_mute_a: assert property (
        (dsp_clk_select == ACSS_CODE_6 && cur_idx[3] == ACSS_SRC_MUTE) [*2]
        |-> !clk_out.dsp)
        else $error("reserved dsp code left the clock running");

endmodule : acss_clock_select

// [common/acss_pkg.sv]
// constants, codes and carriers for the audio clock source select block
// assumes a single core clock; all candidate clocks arrive as sampled levels
package acss_pkg;

    // register offsets
    localparam logic [7:0] ACSS_REG_REF_DSP   = 8'h0d;
    localparam logic [7:0] ACSS_REG_DAC_OSR   = 8'h0e;
    localparam logic [7:0] ACSS_REG_PUMP      = 8'h0f;
    localparam logic [7:0] ACSS_REG_PICK_A    = 8'h10;
    localparam logic [7:0] ACSS_REG_PICK_B    = 8'h11;
    localparam logic [7:0] ACSS_REG_PICK_REF  = 8'h12;

    // reset value and writable bits of each register
    localparam logic [7:0] ACSS_REG_RESET     = 8'h00;
    localparam logic [7:0] ACSS_MASK_TWO      = 8'h77;
    localparam logic [7:0] ACSS_MASK_LOW      = 8'h07;

    // field positions, all fields three bits wide
    localparam int         ACSS_FIELD_W       = 3;
    localparam int         ACSS_LOW_LSB       = 0;
    localparam int         ACSS_HIGH_LSB      = 4;
    localparam int         ACSS_REF_HI_LSB    = 5;
    localparam int         ACSS_REF_LO_BIT    = 4;

    // internal source indices into the candidate vector
    localparam int         ACSS_SRC_N         = 9;
    localparam int         ACSS_SRC_W         = 4;
    localparam logic [3:0] ACSS_SRC_MUTE      = 4'h0;
    localparam logic [3:0] ACSS_SRC_MASTER    = 4'h1;
    localparam logic [3:0] ACSS_SRC_PLL       = 4'h2;
    localparam logic [3:0] ACSS_SRC_OSC       = 4'h3;
    localparam logic [3:0] ACSS_SRC_MCLK      = 4'h4;
    localparam logic [3:0] ACSS_SRC_SCLK      = 4'h5;
    localparam logic [3:0] ACSS_SRC_GPIO0     = 4'h6;
    localparam logic [3:0] ACSS_SRC_GPIO2     = 4'h7;
    localparam logic [3:0] ACSS_SRC_DAC       = 4'h8;

    // field codes
    localparam logic [2:0] ACSS_CODE_0        = 3'h0;
    localparam logic [2:0] ACSS_CODE_1        = 3'h1;
    localparam logic [2:0] ACSS_CODE_2        = 3'h2;
    localparam logic [2:0] ACSS_CODE_3        = 3'h3;
    localparam logic [2:0] ACSS_CODE_4        = 3'h4;
    localparam logic [2:0] ACSS_CODE_5        = 3'h5;
    localparam logic [2:0] ACSS_CODE_6        = 3'h6;
    localparam logic [2:0] ACSS_PICK_GPIO0    = 3'h3;
    localparam logic [2:0] ACSS_PICK_GPIO2    = 3'h5;

    typedef enum logic [2:0] {
        ACSS_SW_FOLLOW = 3'b001,
        ACSS_SW_DRAIN  = 3'b010,
        ACSS_SW_ARM    = 3'b100
    } acss_sw_state_type;

    typedef struct packed {
        logic master;
        logic pll;
        logic osc;
        logic mclk;
        logic sclk;
        logic gpio0;
        logic gpio2;
    } acss_clk_in_type;

    typedef struct packed {
        logic pll_ref;
        logic dsp;
        logic dac;
        logic oversampling;
        logic pump;
    } acss_clk_out_type;

endpackage : acss_pkg

// [design/acss_glitch_free_mux.sv]
// glitch-free selector of one sampled clock level out of a vector
// assumes every source is a level synchronous to core_clk; index 0 is a constant low
module acss_glitch_free_mux #(
    parameter int N = 9,
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset,
    // sources and wanted selection
    input  wire logic [N-1:0] src_vec,
    input  wire logic [W-1:0] want_sel,
    // selected clock and the index it follows
    output logic              clk_out,
    output logic [W-1:0]      cur_sel
);
    import acss_pkg::*;

    acss_sw_state_type state_q, state_d;
    logic [W-1:0]      cur_q, cur_d;
    logic              out_q, out_d;
    logic              sel_level;

    assign sel_level = src_vec[cur_q];

    // old source is let finish its high phase, then the output idles low
    // until the new source is low, so no shortened pulse can escape
    always_comb begin
        state_d = state_q;
        cur_d   = cur_q;
        out_d   = sel_level;
        unique case (state_q)
            ACSS_SW_FOLLOW: begin
                if (want_sel != cur_q) begin
                    state_d = ACSS_SW_DRAIN;
                end
            end
            ACSS_SW_DRAIN: begin
                if (!sel_level) begin
                    cur_d   = want_sel;
                    state_d = ACSS_SW_ARM;
                end
            end
            ACSS_SW_ARM: begin
                out_d = 1'b0;
                if (!sel_level) begin
                    state_d = ACSS_SW_FOLLOW;
                end
            end
            default: begin
                state_d = ACSS_SW_FOLLOW;
                out_d   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q <= ACSS_SW_FOLLOW;
            cur_q   <= '0;
            out_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cur_q   <= cur_d;
            out_q   <= out_d;
        end
    end

    assign clk_out = out_q;
    assign cur_sel = cur_q;

    rise_from_src_a: assert property (
        @(posedge core_clk) disable iff (reset)
        $rose(out_q) |-> $past(sel_level) && state_q != ACSS_SW_ARM)
        else $error("clock output rose without its source high");

    switch_low_a: assert property (
        @(posedge core_clk) disable iff (reset)
        $changed(cur_q) |-> !out_q ##1 !out_q)
        else $error("clock output not held low across a switch");

    mute_low_a: assert property (
        @(posedge core_clk) disable iff (reset)
        (cur_q == '0) [*2] |-> !out_q)
        else $error("muted clock is toggling");

endmodule : acss_glitch_free_mux

// [tb/acss_clock_select_tb_top.sv]
// self-checking bench for the audio clock source select block
// assumes candidate clocks are levels driven on core_clk; each source has its own pattern
module acss_clock_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import acss_pkg::*;

    logic             core_clk;
    logic             reset;
    logic [7:0]       reg_addr;
    logic [7:0]       reg_wdata;
    logic             reg_wr;
    logic             reg_rd;
    logic [7:0]       reg_rdata;
    logic             clock_auto_set;
    logic [2:0]       auto_ref_code;
    acss_clk_in_type  clk_in;
    acss_clk_out_type clk_out;
    logic [3:0]       pll_ref_src;
    logic [7:0]       cnt_q;
    logic [7:0]       regs [0:5];
    logic [4:0]       o1;
    logic [4:0]       o2;
    int               miscompares;
    int               tests_run;

    acss_clock_select acss_clock_select_inst (
        .core_clk       (core_clk),
        .reset          (reset),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .clock_auto_set (clock_auto_set),
        .auto_ref_code  (auto_ref_code),
        .clk_in         (clk_in),
        .clk_out        (clk_out),
        .pll_ref_src    (pll_ref_src)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // every source has a distinct pattern with high phases of at least two cycles
    always @(posedge core_clk) begin
        if (reset) begin
            cnt_q  <= 8'h00;
            clk_in <= '0;
        end else begin
            cnt_q  <= cnt_q + 8'h01;
            clk_in <= '{cnt_q[1], cnt_q[2], cnt_q[3], cnt_q[4], cnt_q[5], cnt_q[6],
                        cnt_q[6] ^ cnt_q[5]};
        end
    end

    // a one-cycle high pulse on any output can only be a truncated source pulse
    always @(negedge core_clk) begin
        if (!reset && ((~o2 & o1 & ~clk_out) !== 5'h00)) begin
            miscompares++;
            $display("mismatch runt pulse expected %h seen %h", 5'h00, ~o2 & o1 & ~clk_out);
        end
        o2 = o1;
        o1 = clk_out;
    end

    function automatic logic [3:0] pick(input logic [2:0] p);
        case (p)
            ACSS_PICK_GPIO0: return ACSS_SRC_GPIO0;
            ACSS_PICK_GPIO2: return ACSS_SRC_GPIO2;
            default:         return ACSS_SRC_MUTE;
        endcase
    endfunction : pick

    function automatic logic [3:0] dec_div(input logic [2:0] c, input logic [2:0] p);
        case (c)
            3'h0:    return ACSS_SRC_MASTER;
            3'h1:    return ACSS_SRC_PLL;
            3'h2:    return ACSS_SRC_OSC;
            3'h3:    return ACSS_SRC_MCLK;
            3'h4:    return ACSS_SRC_SCLK;
            3'h5:    return pick(p);
            default: return ACSS_SRC_MUTE;
        endcase
    endfunction : dec_div

    function automatic logic [3:0] dec_ovs(input logic [2:0] c, input logic [2:0] p);
        if (c == 3'h0) return ACSS_SRC_DAC;
        if (c == 3'h7) return ACSS_SRC_MUTE;
        if (c == 3'h6) return pick(p);
        return dec_div(c - 3'h1, p);
    endfunction : dec_ovs

    function automatic logic [3:0] dec_ref(input logic [2:0] c, input logic [2:0] p);
        case (c)
            3'h0:    return ACSS_SRC_MCLK;
            3'h1:    return ACSS_SRC_SCLK;
            3'h2:    return ACSS_SRC_OSC;
            3'h3:    return pick(p);
            default: return ACSS_SRC_MUTE;
        endcase
    endfunction : dec_ref

    function automatic logic lvl(input logic [3:0] i, input acss_clk_in_type s);
        case (i)
            ACSS_SRC_MASTER: return s.master;
            ACSS_SRC_PLL:    return s.pll;
            ACSS_SRC_OSC:    return s.osc;
            ACSS_SRC_MCLK:   return s.mclk;
            ACSS_SRC_SCLK:   return s.sclk;
            ACSS_SRC_GPIO0:  return s.gpio0;
            ACSS_SRC_GPIO2:  return s.gpio2;
            default:         return 1'b0;
        endcase
    endfunction : lvl

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        if (a >= ACSS_REG_REF_DSP && a <= ACSS_REG_PICK_REF)
            regs[a - ACSS_REG_REF_DSP] = d & ((a == ACSS_REG_PUMP || a == ACSS_REG_PICK_REF) ?
                                              ACSS_MASK_LOW : ACSS_MASK_TWO);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(negedge core_clk);
        tests_run++;
        if (reg_rdata !== e) begin
            miscompares++;
            $display("mismatch reg %h expected %h seen %h", a, e, reg_rdata);
        end
    endtask : rd_chk

    task automatic chk_ref();
        logic [2:0] c;
        logic [3:0] e;
        c = clock_auto_set ? auto_ref_code : regs[0][6:4];
        e = dec_ref(c, regs[5][2:0]);
        tests_run++;
        if (pll_ref_src !== e) begin
            miscompares++;
            $display("mismatch pll_ref_src expected %h seen %h", e, pll_ref_src);
        end
    endtask : chk_ref

    // waits, bounded, for 130 cycles in a row where every output follows its source
    task automatic settle();
        acss_clk_in_type  h1;
        acss_clk_in_type  h2;
        acss_clk_out_type e;
        logic [3:0]       ri;
        logic [3:0]       di;
        logic [3:0]       ci;
        logic [3:0]       oi;
        logic [3:0]       pi;
        int               n;
        int               run;
        // let inputs driven on the calling edge settle before decoding them
        @(negedge core_clk);
        ri  = dec_ref(clock_auto_set ? auto_ref_code : regs[0][6:4], regs[5][2:0]);
        di  = dec_div(regs[0][2:0], regs[3][6:4]);
        ci  = dec_div(regs[1][6:4], regs[3][2:0]);
        oi  = dec_ovs(regs[1][2:0], regs[4][2:0]);
        pi  = dec_ovs(regs[2][2:0], regs[4][6:4]);
        run = 0;
        for (n = 0; n < 800 && run < 130; n++) begin
            @(negedge core_clk);
            e = '{lvl(ri, h1), lvl(di, h1), lvl(ci, h1),
                  (oi == ACSS_SRC_DAC) ? lvl(ci, h2) : lvl(oi, h1),
                  (pi == ACSS_SRC_DAC) ? lvl(ci, h2) : lvl(pi, h1)};
            run = (clk_out === e) ? run + 1 : 0;
            h2  = h1;
            h1  = clk_in;
        end
        tests_run++;
        if (run < 130) begin
            miscompares++;
            $display("mismatch clk_out expected %b seen %b", e, clk_out);
        end
        chk_ref();
    endtask : settle

    task automatic t_regs();
        int i;
        for (i = 0; i < 6; i++) rd_chk(ACSS_REG_REF_DSP + 8'(i), ACSS_REG_RESET);
        for (i = 12; i < 20; i++) wr(8'(i), 8'hff);
        for (i = 12; i < 20; i++) rd_chk(8'(i), (i == 12 || i > 18) ? 8'h00 : regs[i - 13]);
        for (i = 13; i < 19; i++) wr(8'(i), 8'h00);
        // write and read the same offset on consecutive edges
        @(posedge core_clk);
        reg_addr  <= ACSS_REG_DAC_OSR;
        reg_wdata <= 8'hff;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge core_clk);
        reg_rd    <= 1'b0;
        @(negedge core_clk);
        tests_run++;
        if (reg_rdata !== ACSS_MASK_TWO) begin
            miscompares++;
            $display("mismatch reg %h expected %h seen %h", ACSS_REG_DAC_OSR, ACSS_MASK_TWO,
                     reg_rdata);
        end
        wr(ACSS_REG_DAC_OSR, 8'h00);
    endtask : t_regs

    task automatic t_codes();
        int c;
        for (c = 0; c < 8; c++) begin
            wr(ACSS_REG_PICK_A, 8'h33);
            wr(ACSS_REG_PICK_B, 8'h33);
            wr(ACSS_REG_PICK_REF, 8'h03);
            wr(ACSS_REG_REF_DSP, {1'b0, 3'(c), 1'b0, 3'(c)});
            wr(ACSS_REG_DAC_OSR, {1'b0, 3'(c), 1'b0, 3'(c)});
            wr(ACSS_REG_PUMP, {5'h00, 3'(c)});
            settle();
        end
    endtask : t_codes

    task automatic t_picks();
        int p;
        wr(ACSS_REG_REF_DSP, 8'h35);
        wr(ACSS_REG_DAC_OSR, 8'h56);
        wr(ACSS_REG_PUMP, 8'h06);
        for (p = 0; p < 8; p++) begin
            wr(ACSS_REG_PICK_A, {1'b0, 3'(p), 1'b0, 3'(p)});
            wr(ACSS_REG_PICK_B, {1'b0, 3'(p), 1'b0, 3'(p)});
            wr(ACSS_REG_PICK_REF, {5'h00, 3'(p)});
            settle();
        end
    endtask : t_picks

    task automatic t_auto();
        int a;
        wr(ACSS_REG_REF_DSP, 8'h00);
        wr(ACSS_REG_PICK_REF, 8'h05);
        for (a = 0; a < 8; a++) begin
            @(posedge core_clk);
            clock_auto_set <= 1'b1;
            auto_ref_code  <= 3'(a);
            @(negedge core_clk);
            chk_ref();
        end
        @(posedge core_clk);
        auto_ref_code <= 3'h2;
        settle();
        @(posedge core_clk);
        clock_auto_set <= 1'b0;
        settle();
    endtask : t_auto

    task automatic results();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    initial begin
        reset          = 1'b1;
        reg_addr       = 8'h00;
        reg_wdata      = 8'h00;
        reg_wr         = 1'b0;
        reg_rd         = 1'b0;
        clock_auto_set = 1'b0;
        auto_ref_code  = 3'h0;
        miscompares    = 0;
        tests_run      = 0;
        for (int i = 0; i < 6; i++) regs[i] = ACSS_REG_RESET;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        t_regs();
        t_codes();
        t_picks();
        t_auto();
        results();
    end
endmodule : acss_clock_select_tb_top
